// ---- iwr_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "iwr_defs.svh"

module iwr_top #(
  // Device code value is arbitrary
  parameter logic [6:0] DEVICE_CODE = 7'h2D,
  parameter int unsigned POWERUP_CYCLES = `IWR_POWERUP_CYCLES
) (
  input wire logic clk,                               // System clock, 250 MHz
  input wire logic rst,                               // Async reset, active high
  input wire logic scl_i,                             // Serial clock pin
  input wire logic sda_i,                             // Serial data pin level
  output logic sda_o,                                 // Serial data drive value
  output logic sda_oe,                                // High while pulling data low
  output logic [`IWR_WIPER_W-1:0] wiper_position,     // Wiper position register
  output logic [`IWR_TAPS-1:0] tap_sel                // One-hot resistor_ladder tap
);

  iwr_link_if lk ();

  iwr_pin_sync u_sync (
    .clk(clk),
    .rst(rst),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .lk(lk.src)
  );

  iwr_pkg::iwr_core_type s_r;
  iwr_pkg::iwr_core_type s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.sda_drv = 1'b0;
    if (s_r.pu_cnt != '0) begin
      s_nxt.pu_cnt = s_r.pu_cnt - `IWR_PU_W'(1);
    end
    if (lk.start && s_r.pu_cnt == '0) begin
      s_nxt.st = iwr_pkg::ST_ID;
      s_nxt.bit_cnt = '0;
      s_nxt.sda_oe = 1'b0;
      s_nxt.master_ack = 1'b0;
    end else if (lk.stop) begin
      s_nxt.st = iwr_pkg::ST_IDLE;
      s_nxt.sda_oe = 1'b0;
      s_nxt.addr_ok = 1'b0;
    end else begin
      case (s_r.st)
        iwr_pkg::ST_IDLE, iwr_pkg::ST_IGNORE: begin
          s_nxt.sda_oe = 1'b0;
        end
        iwr_pkg::ST_ID, iwr_pkg::ST_ADDR, iwr_pkg::ST_WDATA: begin
          if (lk.scl_rise && s_r.bit_cnt != `IWR_BYTE_BITS) begin
            s_nxt.shift = {s_r.shift[6:0], lk.sda_lvl};
            s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
          end else if (lk.scl_fall && s_r.bit_cnt == `IWR_BYTE_BITS) begin
            s_nxt.bit_cnt = '0;
            s_nxt.sda_oe = 1'b1;
            s_nxt.st = iwr_pkg::ST_ACK;
            if (s_r.st == iwr_pkg::ST_ID) begin
              if (s_r.shift[7:1] != DEVICE_CODE) begin
                s_nxt.sda_oe = 1'b0;
                s_nxt.st = iwr_pkg::ST_IGNORE;
              end else if (s_r.shift[0] == `IWR_DIR_READ) begin
                // Read needs an address set since the last STOP
                if (s_r.addr_ok) begin
                  s_nxt.after_ack = iwr_pkg::ST_RDATA;
                end else begin
                  s_nxt.sda_oe = 1'b0;
                  s_nxt.st = iwr_pkg::ST_IGNORE;
                end
              end else begin
                s_nxt.after_ack = iwr_pkg::ST_ADDR;
              end
            end else if (s_r.st == iwr_pkg::ST_ADDR) begin
              if (s_r.shift == `IWR_WIPER_ADDR) begin
                s_nxt.addr_ok = 1'b1;
                s_nxt.after_ack = iwr_pkg::ST_WDATA;
              end else begin
                s_nxt.addr_ok = 1'b0;
                s_nxt.sda_oe = 1'b0;
                s_nxt.st = iwr_pkg::ST_IGNORE;
              end
            end else begin
              // Commit on the fall that ends the last data bit
              s_nxt.wiper = s_r.shift[`IWR_WIPER_W-1:0];
              s_nxt.after_ack = iwr_pkg::ST_IGNORE;
            end
          end
        end
        iwr_pkg::ST_ACK: begin
          if (lk.scl_fall) begin
            s_nxt.st = s_r.after_ack;
            s_nxt.bit_cnt = '0;
            s_nxt.sda_oe = 1'b0;
            if (s_r.after_ack == iwr_pkg::ST_RDATA) begin
              s_nxt.shift = {1'b0, s_r.wiper};
              s_nxt.sda_oe = 1'b1;
            end
          end
        end
        iwr_pkg::ST_RDATA: begin
          if (lk.scl_fall) begin
            if (s_r.bit_cnt == `IWR_LAST_TX_BIT) begin
              s_nxt.sda_oe = 1'b0;
              s_nxt.st = iwr_pkg::ST_RACK;
              s_nxt.bit_cnt = '0;
              s_nxt.master_ack = 1'b0;
            end else begin
              s_nxt.shift = {s_r.shift[6:0], 1'b0};
              s_nxt.sda_oe = ~s_r.shift[6];
              s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
            end
          end
        end
        iwr_pkg::ST_RACK: begin
          if (lk.scl_rise) begin
            s_nxt.master_ack = ~lk.sda_lvl;
          end else if (lk.scl_fall) begin
            if (s_r.master_ack) begin
              s_nxt.shift = {1'b0, s_r.wiper};
              s_nxt.sda_oe = 1'b1;
              s_nxt.st = iwr_pkg::ST_RDATA;
            end else begin
              s_nxt.sda_oe = 1'b0;
              s_nxt.st = iwr_pkg::ST_IGNORE;
            end
          end
        end
        default: begin
          s_nxt.st = iwr_pkg::ST_IDLE;
          s_nxt.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r.st <= iwr_pkg::ST_IDLE;
      s_r.after_ack <= iwr_pkg::ST_IDLE;
      s_r.bit_cnt <= '0;
      s_r.shift <= '0;
      s_r.addr_ok <= 1'b0;
      s_r.master_ack <= 1'b0;
      s_r.sda_oe <= 1'b0;
      s_r.sda_drv <= 1'b0;
      s_r.pu_cnt <= `IWR_PU_W'(POWERUP_CYCLES);
      s_r.wiper <= `IWR_WIPER_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  iwr_tap_decode #(
    .TAPS(`IWR_TAPS)
  ) u_tap (
    .clk(clk),
    .rst(rst),
    .wiper(s_r.wiper),
    .tap_sel(tap_sel)
  );

  assign sda_o = s_r.sda_drv;
  assign sda_oe = s_r.sda_oe;
  assign wiper_position = s_r.wiper;

  // Clock falling edges with no START or STOP beside them
  logic clean_fall;
  logic byte_end;
  always_comb begin
    clean_fall = lk.scl_fall && !lk.start && !lk.stop;
    byte_end = clean_fall && s_r.bit_cnt == `IWR_BYTE_BITS;
  end

  // Bus states in which the data pin stays released
  function automatic logic quiet(input iwr_pkg::iwr_state_type st);
    return st == iwr_pkg::ST_IDLE || st == iwr_pkg::ST_IGNORE;
  endfunction

  default clocking cb @(posedge clk);
  endclocking

  default disable iff (rst);

  AST_RESET_VALUE: assert property (
    $fell(rst) |-> wiper_position == `IWR_WIPER_RESET)
    else $error("wiper not at preset after reset");

  AST_IDLE_RELEASED: assert property (
    quiet(s_r.st) |-> !sda_oe)
    else $error("data pin driven while idle");

  AST_PU_IGNORE: assert property (
    (s_r.pu_cnt != '0 && lk.start && !lk.stop && s_r.st == iwr_pkg::ST_IDLE)
      |=> s_r.st == iwr_pkg::ST_IDLE)
    else $error("start accepted during power-up");

  AST_STOP_IDLE: assert property (
    (lk.stop && !lk.start) |=> s_r.st == iwr_pkg::ST_IDLE && !sda_oe)
    else $error("stop did not return to idle");

  AST_ID_NACK: assert property (
    (s_r.st == iwr_pkg::ST_ID && lk.scl_fall && !lk.start && !lk.stop
      && s_r.bit_cnt == `IWR_BYTE_BITS && s_r.shift[7:1] != DEVICE_CODE)
      |=> !sda_oe && s_r.st == iwr_pkg::ST_IGNORE)
    else $error("foreign identifier acknowledged");

  AST_ADDR_ACK: assert property (
    (s_r.st == iwr_pkg::ST_ADDR && lk.scl_fall && !lk.start && !lk.stop
      && s_r.bit_cnt == `IWR_BYTE_BITS && s_r.shift == `IWR_WIPER_ADDR)
      |=> sda_oe && s_r.st == iwr_pkg::ST_ACK)
    else $error("valid address not acknowledged");

  AST_COMMIT_ONLY: assert property (
    $changed(s_r.wiper) |-> $past(s_r.st) == iwr_pkg::ST_WDATA
      && $past(lk.scl_fall) && $past(s_r.addr_ok))
    else $error("wiper changed outside a write commit");

  AST_READ_TOP_ZERO: assert property (
    (s_r.st == iwr_pkg::ST_RDATA && s_r.bit_cnt == 4'h0) |-> sda_oe)
    else $error("read byte top bit not driven as zero");

  AST_MSB_ORDER: assert property (
    (s_r.st == iwr_pkg::ST_RDATA && lk.scl_fall && !lk.start && !lk.stop
      && s_r.bit_cnt < `IWR_LAST_TX_BIT) |=> sda_oe == !$past(s_r.shift[6]))
    else $error("read bits not sent most significant first");

  AST_ACK_LENGTH: assert property (
    (s_r.st == iwr_pkg::ST_ACK && lk.scl_fall && !lk.start && !lk.stop
      && s_r.after_ack != iwr_pkg::ST_RDATA) |=> !sda_oe)
    else $error("acknowledge not released after ninth clock");

  AST_NO_DRIVE_HIGH: assert property (
    sda_o == 1'b0)
    else $error("data pin driven high");

  AST_PU_COUNTDOWN: assert property (
    s_r.pu_cnt != '0 |=> s_r.pu_cnt == $past(s_r.pu_cnt) - `IWR_PU_W'(1))
    else $error("power-up count not stepping down");

  AST_PU_HOLD: assert property (
    s_r.pu_cnt == '0 |=> s_r.pu_cnt == '0)
    else $error("power-up count restarted without reset");

  AST_START_ID: assert property (
    (lk.start && s_r.pu_cnt == '0) |=> s_r.st == iwr_pkg::ST_ID && !sda_oe
      && s_r.bit_cnt == 4'h0)
    else $error("start not followed by identifier phase");

  AST_IDLE_STAY: assert property (
    (s_r.st == iwr_pkg::ST_IDLE && !lk.start) |=> s_r.st == iwr_pkg::ST_IDLE)
    else $error("idle left without a start");

  AST_IGNORE_STAY: assert property (
    (s_r.st == iwr_pkg::ST_IGNORE && !lk.start && !lk.stop)
      |=> s_r.st == iwr_pkg::ST_IGNORE && !sda_oe)
    else $error("ignore state left without start or stop");

  AST_ID_ACK: assert property (
    (s_r.st == iwr_pkg::ST_ID && byte_end && s_r.shift == {DEVICE_CODE, 1'b0})
      |=> sda_oe && s_r.st == iwr_pkg::ST_ACK && s_r.after_ack == iwr_pkg::ST_ADDR)
    else $error("own write identifier not acknowledged");

  AST_READ_NEEDS_ADDR: assert property (
    (s_r.st == iwr_pkg::ST_ID && byte_end && s_r.shift[0] && !s_r.addr_ok)
      |=> !sda_oe && s_r.st == iwr_pkg::ST_IGNORE)
    else $error("read identifier acknowledged without address");

  AST_READ_ID_ACK: assert property (
    (s_r.st == iwr_pkg::ST_ID && byte_end && s_r.addr_ok
      && s_r.shift == {DEVICE_CODE, 1'b1})
      |=> sda_oe && s_r.after_ack == iwr_pkg::ST_RDATA)
    else $error("read identifier not acknowledged");

  AST_ADDR_NACK: assert property (
    (s_r.st == iwr_pkg::ST_ADDR && byte_end && s_r.shift != `IWR_WIPER_ADDR)
      |=> !sda_oe && s_r.st == iwr_pkg::ST_IGNORE && !s_r.addr_ok)
    else $error("foreign address acknowledged");

  AST_WDATA_ACK: assert property (
    (s_r.st == iwr_pkg::ST_WDATA && byte_end)
      |=> sda_oe && s_r.st == iwr_pkg::ST_ACK && s_r.after_ack == iwr_pkg::ST_IGNORE)
    else $error("write data not acknowledged or standby missed");

  AST_COMMIT_VALUE: assert property (
    (s_r.st == iwr_pkg::ST_WDATA && byte_end)
      |=> s_r.wiper == $past(s_r.shift[`IWR_WIPER_W-1:0]))
    else $error("wiper not loaded with the received byte");

  AST_WDATA_SHIFT: assert property (
    (s_r.st == iwr_pkg::ST_WDATA && lk.scl_rise && !lk.start && !lk.stop
      && s_r.bit_cnt != `IWR_BYTE_BITS)
      |=> s_r.shift == {$past(s_r.shift[6:0]), $past(lk.sda_lvl)})
    else $error("received bits not shifted most significant first");

  AST_ACK_DRIVEN: assert property (
    s_r.st == iwr_pkg::ST_ACK |-> sda_oe)
    else $error("acknowledge clock without data pulled low");

  AST_ACK_TO_NEXT: assert property (
    (s_r.st == iwr_pkg::ST_ACK && clean_fall && s_r.after_ack == iwr_pkg::ST_ADDR)
      |=> s_r.st == iwr_pkg::ST_ADDR && !sda_oe && s_r.bit_cnt == 4'h0)
    else $error("address phase not entered after identifier");

  AST_RACK_RELEASED: assert property (
    s_r.st == iwr_pkg::ST_RACK |-> !sda_oe)
    else $error("data pin held during master acknowledge");

  AST_RACK_SAMPLE: assert property (
    (s_r.st == iwr_pkg::ST_RACK && lk.scl_rise && !lk.start && !lk.stop)
      |=> s_r.master_ack == !$past(lk.sda_lvl))
    else $error("master acknowledge not sampled on rising clock");

  AST_RACK_MORE: assert property (
    (s_r.st == iwr_pkg::ST_RACK && clean_fall && s_r.master_ack)
      |=> s_r.st == iwr_pkg::ST_RDATA && sda_oe && s_r.shift == {1'b0, $past(s_r.wiper)})
    else $error("read byte not resent after master acknowledge");

  AST_RACK_NACK: assert property (
    (s_r.st == iwr_pkg::ST_RACK && clean_fall && !s_r.master_ack)
      |=> s_r.st == iwr_pkg::ST_IGNORE && !sda_oe)
    else $error("data pin not released after master refusal");

  AST_LAST_BIT_RELEASE: assert property (
    (s_r.st == iwr_pkg::ST_RDATA && clean_fall && s_r.bit_cnt == `IWR_LAST_TX_BIT)
      |=> s_r.st == iwr_pkg::ST_RACK && !sda_oe)
    else $error("data pin not released after eighth read bit");

  AST_BIT_CNT_RANGE: assert property (
    s_r.bit_cnt <= `IWR_BYTE_BITS)
    else $error("bit counter beyond one byte");

  COV_WRITE: cover property (
    s_r.st == iwr_pkg::ST_WDATA && lk.scl_fall && s_r.bit_cnt == `IWR_BYTE_BITS);

  COV_READ: cover property (
    s_r.st == iwr_pkg::ST_RACK && lk.scl_fall && !s_r.master_ack);

  COV_READ_MORE: cover property (
    s_r.st == iwr_pkg::ST_RACK && lk.scl_fall && s_r.master_ack);

  COV_BAD_ADDR: cover property (
    s_r.st == iwr_pkg::ST_ADDR && lk.scl_fall && s_r.bit_cnt == `IWR_BYTE_BITS
      && s_r.shift != `IWR_WIPER_ADDR);

  COV_PU_START: cover property (
    s_r.pu_cnt != '0 && lk.start);

endmodule

`default_nettype wire

// ---- iwr_defs.svh ----
// Behaviour
// - Seven-bit volatile register selects wiper tap
// - Code zero picks tap nearest low terminal
// - All ones picks tap nearest high terminal
// - Rising code moves tap monotonically upward
// - Power-up value of register is 20h
// - Bytes travel most significant bit first
// - Slave only, never drives serial clock
// - Data pin released after power-up
// - Ignore bus until START is seen
// - START during power-up sequence is ignored
// - STOP returns device to idle
// - Receiver pulls data low on ninth clock
// - Acknowledge valid identifier, address, write data
// - Identifier: device code plus direction bit
// - Write: identifier, address, data, then standby
// - Commit data on last bit falling edge
// - Bad address or identifier gets no acknowledge
// - Read: identifier, address, restart, identifier
// - Keep sending while master acknowledges
`ifndef IWR_DEFS_SVH
`define IWR_DEFS_SVH

`define IWR_WIPER_W 7
`define IWR_TAPS 128
`define IWR_WIPER_ADDR 8'h00
`define IWR_WIPER_RESET 7'h20
`define IWR_BYTE_BITS 4'h8
`define IWR_LAST_TX_BIT 4'h7
`define IWR_DIR_READ 1'b1
`define IWR_CLK_PERIOD_NS 4
`define IWR_POWERUP_NS 400
`define IWR_POWERUP_CYCLES ((`IWR_POWERUP_NS + `IWR_CLK_PERIOD_NS - 1) / `IWR_CLK_PERIOD_NS)
`define IWR_PU_W 16

`endif

// ---- iwr_pkg.sv ----
`default_nettype none
`include "iwr_defs.svh"

package iwr_pkg;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ID,
    ST_ADDR,
    ST_WDATA,
    ST_ACK,
    ST_RDATA,
    ST_RACK,
    ST_IGNORE
  } iwr_state_type;

  typedef struct packed {
    iwr_state_type st;
    iwr_state_type after_ack;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic addr_ok;
    logic master_ack;
    logic sda_oe;
    logic sda_drv;
    logic [`IWR_PU_W-1:0] pu_cnt;
    logic [`IWR_WIPER_W-1:0] wiper;
  } iwr_core_type;

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_d;
    logic sda_s1;
    logic sda_s2;
    logic sda_d;
  } iwr_sync_type;

  typedef struct packed {
    logic [`IWR_TAPS-1:0] sel;
  } iwr_tap_type;

endpackage

`default_nettype wire

// ---- iwr_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface iwr_link_if;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic sda_lvl;

  modport src (
    output scl_rise,
    output scl_fall,
    output start,
    output stop,
    output sda_lvl
  );

  modport dst (
    input scl_rise,
    input scl_fall,
    input start,
    input stop,
    input sda_lvl
  );
endinterface

`default_nettype wire

// ---- iwr_pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "iwr_defs.svh"

module iwr_pin_sync (
  input wire logic clk,   // System clock
  input wire logic rst,   // Async reset
  input wire logic scl_i, // Serial clock pin, input only
  input wire logic sda_i, // Serial data pin level
  iwr_link_if.src lk      // Edge and condition events
);

  iwr_pkg::iwr_sync_type s_r;
  iwr_pkg::iwr_sync_type s_nxt;

  // Clock is only sampled, never driven
  always_comb begin
    s_nxt = s_r;
    s_nxt.scl_s1 = scl_i;
    s_nxt.scl_s2 = s_r.scl_s1;
    s_nxt.scl_d = s_r.scl_s2;
    s_nxt.sda_s1 = sda_i;
    s_nxt.sda_s2 = s_r.sda_s1;
    s_nxt.sda_d = s_r.sda_s2;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '{scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1,
               sda_s1: 1'b1, sda_s2: 1'b1, sda_d: 1'b1};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Data moving while clock high marks START or STOP
  always_comb begin
    lk.scl_rise = s_r.scl_s2 & ~s_r.scl_d;
    lk.scl_fall = ~s_r.scl_s2 & s_r.scl_d;
    lk.start = s_r.scl_s2 & s_r.scl_d & s_r.sda_d & ~s_r.sda_s2;
    lk.stop = s_r.scl_s2 & s_r.scl_d & ~s_r.sda_d & s_r.sda_s2;
    lk.sda_lvl = s_r.sda_s2;
  end

  AST_START_SHAPE: assert property (@(posedge clk) disable iff (rst)
    lk.start |-> s_r.scl_s2 && $fell(s_r.sda_s2))
    else $error("start flagged without falling data under high clock");

endmodule

`default_nettype wire

// ---- iwr_tap_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "iwr_defs.svh"

module iwr_tap_decode #(
  parameter int unsigned TAPS = `IWR_TAPS
) (
  input wire logic clk,                       // System clock
  input wire logic rst,                       // Async reset
  input wire logic [`IWR_WIPER_W-1:0] wiper,  // Wiper position code
  output logic [TAPS-1:0] tap_sel             // One-hot ladder tap select
);

  iwr_pkg::iwr_tap_type t_r;
  iwr_pkg::iwr_tap_type t_nxt;

  // Bit n closes the switch n taps above the low terminal
  function automatic logic [TAPS-1:0] onehot(input logic [`IWR_WIPER_W-1:0] code);
    logic [TAPS-1:0] v;
    v = '0;
    v[code] = 1'b1;
    return v;
  endfunction

  always_comb begin
    t_nxt = t_r;
    t_nxt.sel = onehot(wiper);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      t_r.sel <= onehot(`IWR_WIPER_RESET);
    end else begin
      t_r <= t_nxt;
    end
  end

  assign tap_sel = t_r.sel;

  AST_TAP_ORDER: assert property (@(posedge clk) disable iff (rst)
    ##1 tap_sel == onehot($past(wiper)))
    else $error("tap select does not follow wiper code");

  AST_TAP_ONEHOT: assert property (@(posedge clk) disable iff (rst)
    $onehot(tap_sel))
    else $error("more or fewer than one tap closed");

endmodule

`default_nettype wire

// ---- iwr_i2c_master.sv ----
`timescale 1ns/1ps
`default_nettype none

module iwr_i2c_master (
  input wire logic clk, // Bench clock
  input wire logic sda, // Resolved data line
  output logic scl,     // Serial clock, driven only here
  output logic sda_oe   // High while pulling data low
);
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end

  task automatic q(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Also serves as repeated start
  task automatic start();
    sda_oe = 1'b0;
    q(3);
    scl = 1'b1;
    q(3);
    sda_oe = 1'b1;
    q(3);
    scl = 1'b0;
    q(3);
  endtask

  task automatic stop();
    sda_oe = 1'b1;
    q(3);
    scl = 1'b1;
    q(3);
    sda_oe = 1'b0;
    q(3);
  endtask

  // Data moves only while clock is low
  task automatic bit_x(input logic b, output logic r);
    sda_oe = ~b;
    q(3);
    scl = 1'b1;
    r = sda;
    q(6);
    scl = 1'b0;
    q(3);
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
    end
    bit_x(1'b1, r);
    ack = ~r;
  endtask

  task automatic rbyte(output logic [7:0] d, input logic more);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, d[i]);
    end
    bit_x(~more, r);
  endtask
endmodule

`default_nettype wire

// ---- i2c_wiper_register_slave_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module i2c_wiper_register_slave_tb;
  // Device code value is arbitrary
  localparam logic [6:0] DEV = 7'h5A;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic scl;
  logic m_oe;
  logic sda_o;
  logic sda_oe;
  logic sda_w;
  logic [6:0] wiper;
  logic [127:0] tap;
  logic [6:0] exp_w = 7'h20;
  int error_cnt = 0;
  int n_tests = 0;

  always #2 clk = ~clk;

  // Pulled up unless someone pulls low
  assign sda_w = ~(m_oe | (sda_oe & ~sda_o));

  iwr_top #(.DEVICE_CODE(DEV), .POWERUP_CYCLES(20)) dut_u (
    .clk(clk),
    .rst(rst),
    .scl_i(scl),
    .sda_i(sda_w),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .wiper_position(wiper),
    .tap_sel(tap)
  );

  iwr_i2c_master m_u (
    .clk(clk),
    .sda(sda_w),
    .scl(scl),
    .sda_oe(m_oe)
  );

  task automatic end_sim();
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
    n_tests++;
    if (e !== g) begin
      error_cnt++;
      $display("BAD %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  function automatic logic [127:0] tap_of(input logic [6:0] c);
    return 128'h1 << c;
  endfunction

  function automatic logic wr_ok(input logic [6:0] code, input logic [7:0] addr);
    return code === DEV && addr === 8'h00;
  endfunction

  task automatic post();
    m_u.q(4);
    chk("wiper", exp_w, wiper);
    chk("tap_sel", tap_of(exp_w), tap);
    chk("idle_release", 1'b0, sda_oe);
    chk("drive_value", 1'b0, sda_o);
  endtask

  task automatic wr(input logic [6:0] code, input logic [7:0] addr, input logic [7:0] d,
                    input logic two);
    logic a0;
    logic a1;
    logic a2;
    logic a3;
    logic ok;
    ok = (code === DEV);
    m_u.start();
    m_u.wbyte({code, 1'b0}, a0);
    m_u.wbyte(addr, a1);
    m_u.wbyte(d, a2);
    if (two) begin
      m_u.wbyte(~d, a3);
      chk("standby_ack", 1'b0, a3);
    end
    m_u.stop();
    chk("id_ack", ok, a0);
    chk("addr_ack", wr_ok(code, addr), a1);
    chk("data_ack", wr_ok(code, addr), a2);
    if (wr_ok(code, addr)) begin
      exp_w = d[6:0];
    end
    post();
  endtask

  task automatic rd(input int n);
    logic a0;
    logic a1;
    logic a2;
    logic [7:0] d;
    m_u.start();
    m_u.wbyte({DEV, 1'b0}, a0);
    m_u.wbyte(8'h00, a1);
    m_u.start();
    m_u.wbyte({DEV, 1'b1}, a2);
    chk("rd_acks", 3'b111, {a0, a1, a2});
    for (int i = 0; i < n; i++) begin
      m_u.rbyte(d, i < n - 1);
      chk("rd_data", {1'b0, exp_w}, d);
    end
    m_u.q(3);
    chk("nack_release", 1'b0, sda_oe);
    m_u.stop();
    post();
  endtask

  initial begin
    #200000;
    error_cnt++;
    end_sim();
  end

  initial begin
    logic a;
    void'($urandom(1265));
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    post();
    // Full byte clocked with no start beforehand
    m_u.wbyte({DEV, 1'b0}, a);
    chk("no_start_ack", 1'b0, a);
    m_u.stop();
    post();
    // Read identifier with no address set since the last STOP
    m_u.start();
    m_u.wbyte({DEV, 1'b1}, a);
    chk("rd_noaddr_ack", 1'b0, a);
    m_u.stop();
    wr(DEV, 8'h00, 8'h00, 1'b0);
    rd(1);
    wr(DEV, 8'h00, 8'hFF, 1'b0);
    rd(3);
    wr(DEV ^ 7'h01, 8'h00, 8'h11, 1'b0);
    wr(DEV, 8'h01, 8'h22, 1'b0);
    wr(DEV, 8'h80, 8'h33, 1'b0);
    wr(DEV, 8'h00, 8'hC5, 1'b1);
    rd(2);
    // Reset in mid-run, then a START inside the power-up window
    rst = 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    exp_w = 7'h20;
    m_u.start();
    m_u.wbyte({DEV, 1'b0}, a);
    chk("pu_start_ack", 1'b0, a);
    m_u.stop();
    post();
    for (int i = 0; i < 14; i++) begin
      wr(($urandom % 4 == 0) ? 7'($urandom) : DEV,
         ($urandom % 4 == 0) ? 8'($urandom) : 8'h00,
         8'($urandom), 1'($urandom));
      rd(1 + $urandom % 3);
    end
    end_sim();
  end
endmodule

`default_nettype wire
